// *** rtl/dam_monitor.sv ***
// dual alarm monitor: host registers, two alarms, indicator pins
// Function
// - diagnostic bits 9 and 8 mirror alarms
// - alarm two source in bits 15:12
// - codes 7,8,9: temperature, aux, diag nonzero
// - alarm one source in bits 11:8
// - bit 7 dynamic mode for alarm two
// - bit 6 dynamic mode for alarm one
// - bit 5 greater-than polarity alarm two
// - bit 4 greater-than polarity alarm one
// - bit 3 selects filtered source data
// - bit 2 enables the indicator output
// - bit 1 makes indicator active high
// - bit 0 routes indicator to line two
// - control word resets to zero
// - dynamic compares change across sample window
// - static compares source against threshold directly
// - window bits 7:0, zero and one mean one
module dam_monitor
    import dam_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     nrst,
    input  wire logic                     hostValid,
    input  wire logic [15:0]              hostWord,
    output logic                          rdValid_q,
    output logic [15:0]                   rdData_q,
    input  wire logic                     sampleValid,
    input  wire logic [dam_pkg::NUM_SRC-1:0][15:0] rawSrc,
    input  wire logic [dam_pkg::NUM_SRC-1:0][15:0] filtSrc,
    input  wire logic [15:0]              diagIn,
    output logic [15:0]                   diagnosticFlagsWord_q,
    output logic                          generalIoLineOneOut_q,
    output logic                          generalIoLineOneOeN_q,
    output logic                          generalIoLineTwoOut_q,
    output logic                          generalIoLineTwoOeN_q
);
    import dam_pkg::*;

    logic [15:0] alarmControlWord_q, alarmControlWord_d;
    logic [15:0] alarmOneThreshold_q, alarmOneThreshold_d;
    logic [15:0] alarmTwoThreshold_q, alarmTwoThreshold_d;
    logic [7:0]  alarmOneSampleWindow_q, alarmOneSampleWindow_d;
    logic [7:0]  alarmTwoSampleWindow_q, alarmTwoSampleWindow_d;
    logic [15:0] rdData_d;
    logic        rdValid_d;
    logic [6:0]  hostAddr;
    logic [6:0]  wordAddr;
    logic [7:0]  hostByte;
    logic        wrEn;
    logic        rdEn;
    logic        hitOne;
    logic        hitTwo;
    logic        diagNonzero;
    logic [15:0] diag_d;
    logic        indLevel;
    logic        oneOut_d, oneOeN_d, twoOut_d, twoOeN_d;

    // ****************************************************************
    // host word decode
    // ****************************************************************
    // each host word carries one byte; a 16-bit register takes two words
    always_comb
    begin
        hostAddr = hostWord[HOST_ADDR_MSB:HOST_ADDR_LSB];
        hostByte = hostWord[HOST_DATA_MSB:0];
        wordAddr = {hostAddr[6:1], 1'b0};
        wrEn     = hostValid && hostWord[HOST_WR_BIT];
        rdEn     = hostValid && !hostWord[HOST_WR_BIT];
    end

    // ****************************************************************
    // register writes
    // ****************************************************************
    // byte writes land independently, so order of halves is free here
    always_comb
    begin
        alarmControlWord_d     = alarmControlWord_q;
        alarmOneThreshold_d    = alarmOneThreshold_q;
        alarmTwoThreshold_d    = alarmTwoThreshold_q;
        alarmOneSampleWindow_d = alarmOneSampleWindow_q;
        alarmTwoSampleWindow_d = alarmTwoSampleWindow_q;
        if (wrEn)
        begin
            case (hostAddr)
                ADDR_CTRL:             alarmControlWord_d[7:0]   = hostByte;
                ADDR_CTRL + 7'h01:     alarmControlWord_d[15:8]  = hostByte;
                ADDR_THR_ONE:          alarmOneThreshold_d[7:0]  = hostByte;
                ADDR_THR_ONE + 7'h01:  alarmOneThreshold_d[15:8] = hostByte;
                ADDR_THR_TWO:          alarmTwoThreshold_d[7:0]  = hostByte;
                ADDR_THR_TWO + 7'h01:  alarmTwoThreshold_d[15:8] = hostByte;
                ADDR_WIN_ONE:          alarmOneSampleWindow_d    = hostByte;
                ADDR_WIN_TWO:          alarmTwoSampleWindow_d    = hostByte;
                default:               ;
            endcase
        end
    end

    // ****************************************************************
    // register reads
    // ****************************************************************
    // unused window bits and unmapped addresses read as zero
    always_comb
    begin
        rdValid_d = rdEn;
        rdData_d  = rdData_q;
        if (rdEn)
        begin
            case (wordAddr)
                ADDR_CTRL:    rdData_d = alarmControlWord_q;
                ADDR_THR_ONE: rdData_d = alarmOneThreshold_q;
                ADDR_THR_TWO: rdData_d = alarmTwoThreshold_q;
                ADDR_WIN_ONE: rdData_d = {8'h00, alarmOneSampleWindow_q};
                ADDR_WIN_TWO: rdData_d = {8'h00, alarmTwoSampleWindow_q};
                ADDR_DIAG:    rdData_d = diagnosticFlagsWord_q;
                default:      rdData_d = 16'h0000;
            endcase
        end
    end

    // register bank and read port
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            alarmControlWord_q     <= CTRL_RESET;
            alarmOneThreshold_q    <= THR_RESET;
            alarmTwoThreshold_q    <= THR_RESET;
            alarmOneSampleWindow_q <= WIN_RESET;
            alarmTwoSampleWindow_q <= WIN_RESET;
            rdValid_q              <= 1'b0;
            rdData_q               <= 16'h0000;
        end
        else
        begin
            alarmControlWord_q     <= alarmControlWord_d;
            alarmOneThreshold_q    <= alarmOneThreshold_d;
            alarmTwoThreshold_q    <= alarmTwoThreshold_d;
            alarmOneSampleWindow_q <= alarmOneSampleWindow_d;
            alarmTwoSampleWindow_q <= alarmTwoSampleWindow_d;
            rdValid_q              <= rdValid_d;
            rdData_q               <= rdData_d;
        end
    end

    // ****************************************************************
    // alarm channels
    // ****************************************************************
    // alarm bits are masked out so a raised alarm cannot hold itself up
    assign diagNonzero = (diagIn & ~16'h0300) != 16'h0000;

    dam_alarm_unit u_alarmOne (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .srcSel      (alarmControlWord_q[CTRL_SRC_ONE_LSB +: 4]),
        .dynMode     (alarmControlWord_q[CTRL_DYN_ONE]),
        .gtPol       (alarmControlWord_q[CTRL_GT_ONE]),
        .useFilt     (alarmControlWord_q[CTRL_FILT]),
        .window      (alarmOneSampleWindow_q),
        .threshold   (alarmOneThreshold_q),
        .sampleValid (sampleValid),
        .rawSrc      (rawSrc),
        .filtSrc     (filtSrc),
        .diagNonzero (diagNonzero),
        .alarmHit_q  (hitOne)
    );

    dam_alarm_unit u_alarmTwo (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .srcSel      (alarmControlWord_q[CTRL_SRC_TWO_LSB +: 4]),
        .dynMode     (alarmControlWord_q[CTRL_DYN_TWO]),
        .gtPol       (alarmControlWord_q[CTRL_GT_TWO]),
        .useFilt     (alarmControlWord_q[CTRL_FILT]),
        .window      (alarmTwoSampleWindow_q),
        .threshold   (alarmTwoThreshold_q),
        .sampleValid (sampleValid),
        .rawSrc      (rawSrc),
        .filtSrc     (filtSrc),
        .diagNonzero (diagNonzero),
        .alarmHit_q  (hitTwo)
    );

    // ****************************************************************
    // diagnostic word and indicator pins
    // ****************************************************************
    // unused line is released (enable high) rather than driven idle
    always_comb
    begin
        diag_d = diagIn;
        diag_d[DIAG_ALARM_TWO] = hitTwo;
        diag_d[DIAG_ALARM_ONE] = hitOne;
        indLevel = alarmControlWord_q[CTRL_IND_HIGH] ? (hitOne | hitTwo)
                                                     : !(hitOne | hitTwo);
        oneOut_d = 1'b0;
        oneOeN_d = 1'b1;
        twoOut_d = 1'b0;
        twoOeN_d = 1'b1;
        if (alarmControlWord_q[CTRL_IND_EN])
        begin
            if (alarmControlWord_q[CTRL_LINE_TWO])
            begin
                twoOut_d = indLevel;
                twoOeN_d = 1'b0;
            end
            else
            begin
                oneOut_d = indLevel;
                oneOeN_d = 1'b0;
            end
        end
    end

    // output flops
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            diagnosticFlagsWord_q <= 16'h0000;
            generalIoLineOneOut_q <= 1'b0;
            generalIoLineOneOeN_q <= 1'b1;
            generalIoLineTwoOut_q <= 1'b0;
            generalIoLineTwoOeN_q <= 1'b1;
        end
        else
        begin
            diagnosticFlagsWord_q <= diag_d;
            generalIoLineOneOut_q <= oneOut_d;
            generalIoLineOneOeN_q <= oneOeN_d;
            generalIoLineTwoOut_q <= twoOut_d;
            generalIoLineTwoOeN_q <= twoOeN_d;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence ctrlHighWrite;
        wrEn && hostAddr == ADDR_CTRL + 7'h01;
    endsequence

    sequence ctrlLowWrite;
        wrEn && hostAddr == ADDR_CTRL;
    endsequence

    diag_flags_a: assert property (##1 diagnosticFlagsWord_q[9:8] == $past({hitTwo, hitOne}))
        else $error("diag alarm flags do not track alarms");
    ctrl_hold_a: assert property (!(wrEn && wordAddr == ADDR_CTRL)
        |=> $stable(alarmControlWord_q))
        else $error("control word changed without write");
    ctrl_pair_a: assert property (ctrlHighWrite ##1 ctrlLowWrite
        |=> alarmControlWord_q == {$past(hostByte, 2), $past(hostByte)})
        else $error("control word pair not assembled");
    src_one_off_a: assert property (alarmControlWord_q[11:8] == SRC_OFF
        |=> !hitOne)
        else $error("alarm one raised while disabled");
    ind_off_a: assert property (!alarmControlWord_q[CTRL_IND_EN]
        |=> generalIoLineOneOeN_q && generalIoLineTwoOeN_q)
        else $error("indicator driven while disabled");
    ind_line_a: assert property (alarmControlWord_q[CTRL_IND_EN]
        |=> (generalIoLineTwoOeN_q == !$past(alarmControlWord_q[CTRL_LINE_TWO]))
        && (generalIoLineOneOeN_q == $past(alarmControlWord_q[CTRL_LINE_TWO])))
        else $error("indicator on wrong line");
    ind_pol_a: assert property (alarmControlWord_q[CTRL_IND_EN]
        && !alarmControlWord_q[CTRL_LINE_TWO]
        |=> generalIoLineOneOut_q == ($past(alarmControlWord_q[CTRL_IND_HIGH])
        == $past(hitOne | hitTwo)))
        else $error("indicator polarity wrong");
    win_read_a: assert property (rdEn && wordAddr == ADDR_WIN_ONE
        |=> rdValid_q && rdData_q[15:8] == 8'h00)
        else $error("window upper bits not zero");

endmodule : dam_monitor

// *** rtl/dam_pkg.sv ***
// shared constants for the dual alarm monitor
package dam_pkg;

    // ****************************************************************
    // host word layout: write flag, byte address, data byte
    // ****************************************************************
    localparam int HOST_WR_BIT   = 15;
    localparam int HOST_ADDR_MSB = 14;
    localparam int HOST_ADDR_LSB = 8;
    localparam int HOST_DATA_MSB = 7;

    // ****************************************************************
    // register byte addresses (even = low byte, odd = high byte)
    // ****************************************************************
    localparam logic [6:0] ADDR_THR_ONE  = 7'h26;
    localparam logic [6:0] ADDR_THR_TWO  = 7'h28;
    localparam logic [6:0] ADDR_WIN_ONE  = 7'h2a;
    localparam logic [6:0] ADDR_WIN_TWO  = 7'h2c;
    localparam logic [6:0] ADDR_CTRL     = 7'h2e;
    localparam logic [6:0] ADDR_DIAG     = 7'h3c;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [15:0] THR_RESET    = 16'h0000;
    localparam logic [7:0]  WIN_RESET    = 8'h00;

    // ****************************************************************
    // alarm control word fields
    // ****************************************************************
    localparam int CTRL_SRC_TWO_LSB = 12;
    localparam int CTRL_SRC_ONE_LSB = 8;
    localparam int CTRL_DYN_TWO     = 7;
    localparam int CTRL_DYN_ONE     = 6;
    localparam int CTRL_GT_TWO      = 5;
    localparam int CTRL_GT_ONE      = 4;
    localparam int CTRL_FILT        = 3;
    localparam int CTRL_IND_EN      = 2;
    localparam int CTRL_IND_HIGH    = 1;
    localparam int CTRL_LINE_TWO    = 0;

    // ****************************************************************
    // diagnostic word alarm flag positions
    // ****************************************************************
    localparam int DIAG_ALARM_TWO   = 9;
    localparam int DIAG_ALARM_ONE   = 8;

    // ****************************************************************
    // source codes; 1..6 rate x,y,z then accel x,y,z
    // ****************************************************************
    localparam logic [3:0] SRC_OFF     = 4'h0;
    localparam logic [3:0] SRC_FIRST   = 4'h1;
    localparam logic [3:0] SRC_TEMP    = 4'h7;
    localparam logic [3:0] SRC_AUX     = 4'h8;
    localparam logic [3:0] SRC_DIAG    = 4'h9;
    localparam int         NUM_SRC     = 8;

    // ****************************************************************
    // sample window
    // ****************************************************************
    localparam int         WIN_DEPTH   = 256;
    localparam logic [7:0] WIN_MIN     = 8'h01;
    localparam int         SAMPLE_RATE_SPS = 1024;

endpackage : dam_pkg

// *** rtl/dam_alarm_unit.sv ***
// one alarm channel: source select, history window, comparison
module dam_alarm_unit
    import dam_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   nrst,
    input  wire logic [3:0]             srcSel,
    input  wire logic                   dynMode,
    input  wire logic                   gtPol,
    input  wire logic                   useFilt,
    input  wire logic [7:0]             window,
    input  wire logic [15:0]            threshold,
    input  wire logic                   sampleValid,
    input  wire logic [NUM_SRC-1:0][15:0] rawSrc,
    input  wire logic [NUM_SRC-1:0][15:0] filtSrc,
    input  wire logic                   diagNonzero,
    output logic                        alarmHit_q
);
    logic [15:0] hist [WIN_DEPTH];
    logic [7:0]  wrPtr_q, wrPtr_d, fill_q, fill_d, winEff, rdPtr;
    logic [3:0]  idxFull;
    logic [15:0] cur, old;
    logic signed [16:0] val, thr;
    logic        filled, cmpHit, alarmHit_d;

    // ****************************************************************
    // source select and comparison
    // ****************************************************************
    // a window of 0 or 1 both mean one sample back
    always_comb
    begin
        winEff  = (window < WIN_MIN) ? WIN_MIN : window;
        idxFull = srcSel - SRC_FIRST;
        cur     = useFilt ? filtSrc[idxFull[2:0]] : rawSrc[idxFull[2:0]];
        rdPtr   = wrPtr_q - winEff;
        old     = hist[rdPtr];
        filled  = (fill_q >= winEff);
        thr     = {threshold[15], threshold};
        if (dynMode)
            val = 17'(signed'({cur[15], cur}) - signed'({old[15], old}));
        else
            val = {cur[15], cur};
        cmpHit  = gtPol ? (val > thr) : (val < thr);
        // without a full window no dynamic verdict is possible
        if (dynMode && !filled)
            cmpHit = 1'b0;
        alarmHit_d = alarmHit_q;
        if (srcSel == SRC_OFF || srcSel > SRC_DIAG)
            alarmHit_d = 1'b0;
        else if (sampleValid)
            alarmHit_d = (srcSel == SRC_DIAG) ? diagNonzero : cmpHit;
        wrPtr_d = sampleValid ? wrPtr_q + 8'h01 : wrPtr_q;
        fill_d  = (sampleValid && fill_q != 8'hff) ? fill_q + 8'h01 : fill_q;
    end

    // history is not flushed on a source change; the first window mixes
    always_ff @(posedge ref_clk)
    begin
        if (sampleValid)
            hist[wrPtr_q] <= cur;
    end

    // state registers
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrPtr_q    <= 8'h00;
            fill_q     <= 8'h00;
            alarmHit_q <= 1'b0;
        end
        else
        begin
            wrPtr_q    <= wrPtr_d;
            fill_q     <= fill_d;
            alarmHit_q <= alarmHit_d;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    win_floor_a: assert property (window <= WIN_MIN |-> winEff == WIN_MIN)
        else $error("window below one not treated as one");
    src_off_a: assert property (srcSel == SRC_OFF |=> !alarmHit_q)
        else $error("disabled alarm still raised");
    diag_src_a: assert property (sampleValid && srcSel == SRC_DIAG
        |=> alarmHit_q == $past(diagNonzero))
        else $error("diag source verdict wrong");
    static_cmp_a: assert property (sampleValid && !dynMode && srcSel inside {[1:8]}
        |=> alarmHit_q == $past(gtPol ? val > thr : val < thr))
        else $error("static comparison wrong");
    dyn_fill_a: assert property (sampleValid && dynMode && !filled
        && srcSel inside {[1:8]} |=> !alarmHit_q)
        else $error("dynamic alarm before window filled");
    dyn_delta_a: assert property (sampleValid && dynMode && filled && srcSel != SRC_OFF
        && srcSel < SRC_DIAG |-> val == 17'(signed'({cur[15], cur})
        - signed'({old[15], old})))
        else $error("dynamic delta wrong");

endmodule : dam_alarm_unit

// *** dv/dam_host_model.sv ***
// host processor model driving the host word port of the alarm monitor
module dam_host_model
(
    output logic        hostValid,
    output logic [15:0] hostWord,
    input  wire logic   ref_clk
);
    timeunit 1ns;
    timeprecision 100ps;

    // ************************************************************
    // host word sequencing
    // ************************************************************
    // idle before the first word
    initial
    begin
        hostValid = 1'b0;
        hostWord  = 16'h0000;
    end

    // one word per edge; an idle port shows the inverse so stale words never look fresh
    task automatic putWord(input logic [15:0] w, input bit last);
        @(posedge ref_clk);
        #1 hostValid = 1'b1;
        hostWord = w;
        if (last)
        begin
            @(posedge ref_clk);
            #1 hostValid = 1'b0;
            hostWord = ~w;
        end
    endtask : putWord

    // high byte first, then low byte, back to back
    task automatic wr16(input logic [6:0] a, input logic [15:0] d);
        putWord({1'b1, a | 7'h01, d[15:8]}, 1'b0);
        putWord({1'b1, a & 7'h7e, d[7:0]}, 1'b1);
    endtask : wr16

    task automatic wr8(input logic [6:0] a, input logic [7:0] d);
        putWord({1'b1, a, d}, 1'b1);
    endtask : wr8

    task automatic rd(input logic [6:0] a);
        putWord({1'b0, a, 8'h00}, 1'b1);
    endtask : rd
endmodule : dam_host_model

// *** dv/dam_monitor_tb_top.sv ***
// self-checking bench for the dual alarm monitor
module dam_monitor_tb_top
    import dam_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                    ref_clk;
    logic                    nrst;
    logic                    hostValid;
    logic [15:0]             hostWord;
    logic                    rdValid;
    logic [15:0]             rdData;
    logic                    sampleValid;
    logic [NUM_SRC-1:0][15:0] rawSrc;
    logic [NUM_SRC-1:0][15:0] filtSrc;
    logic [15:0]             diagIn;
    logic [15:0]             diagWord;
    logic                    l1Out;
    logic                    l1OeN;
    logic                    l2Out;
    logic                    l2OeN;
    int                      err_count = 0;
    int                      n_tests = 0;
    integer                  seed = 32'hbd38c9dd;
    logic [15:0]             expQ[$];
    logic [15:0]             hist[$];

    dam_monitor i_dam_monitor (.ref_clk(ref_clk), .nrst(nrst), .hostValid(hostValid),
        .hostWord(hostWord), .rdValid_q(rdValid), .rdData_q(rdData),
        .sampleValid(sampleValid), .rawSrc(rawSrc), .filtSrc(filtSrc), .diagIn(diagIn),
        .diagnosticFlagsWord_q(diagWord), .generalIoLineOneOut_q(l1Out),
        .generalIoLineOneOeN_q(l1OeN), .generalIoLineTwoOut_q(l2Out),
        .generalIoLineTwoOeN_q(l2OeN));

    dam_host_model i_dam_host_model (.hostValid(hostValid), .hostWord(hostWord),
        .ref_clk(ref_clk));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic test_done();
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // small signed values keep window differences inside 16 bits
    function automatic logic [15:0] rnd();
        return 16'($random(seed) % 2000);
    endfunction : rnd

    task automatic rdChk(input logic [6:0] a, input logic [15:0] e);
        expQ.push_back(e);
        i_dam_host_model.rd(a);
    endtask : rdChk

    // one sample pulse; flags and pins land one edge after the take edge
    task automatic pulse();
        @(posedge ref_clk);
        #1 sampleValid = 1'b1;
        @(posedge ref_clk);
        #1 sampleValid = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : pulse

    task automatic chkAlarm(input logic [15:0] ctl, input logic h1, input logic h2);
        logic lvl;
        logic [3:0] pins;
        lvl = ctl[1] ? (h1 | h2) : ~(h1 | h2);
        pins = ~ctl[2] ? 4'b1010 : (ctl[0] ? {1'b0, lvl, 2'b10} : {2'b10, 1'b0, lvl});
        check("diag word", {diagIn[15:10], h2, h1, diagIn[7:0]}, diagWord);
        check("pins", {12'h000, pins}, {12'h000, l2OeN, l2Out, l1OeN, l1Out});
    endtask : chkAlarm

    // ************************************************************
    // clock, watchdog, read scoreboard
    // ************************************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    initial
    begin
        #60000;
        err_count++;
        test_done();
    end

    // each read answer takes the oldest pending note
    always @(posedge ref_clk)
    begin
        if (rdValid === 1'b1)
        begin
            if (expQ.size() == 0)
                check("unexpected read", 16'h0000, 16'hffff);
            else
                check("read data", expQ.pop_front(), rdData);
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        logic [15:0] ctl;
        logic [15:0] thr;
        logic [15:0] v;
        logic [15:0] d;
        logic        hit;
        int          n;
        nrst = 1'b0;
        sampleValid = 1'b0;
        rawSrc = '0;
        filtSrc = '0;
        diagIn = 16'h0000;
        repeat (20) @(posedge ref_clk);
        #1 nrst = 1'b1;
        diagIn = 16'h5a0f;
        rdChk(ADDR_CTRL, 16'h0000);
        chkAlarm(16'h0000, 1'b0, 1'b0);
        rdChk(7'h40, 16'h0000);
        i_dam_host_model.wr16(ADDR_CTRL, 16'h36af);
        rdChk(ADDR_CTRL, 16'h36af);
        // static: every source code on each alarm, random polarity, filter and pins
        for (int c = 0; c < 16; c++)
            for (int a = 0; a < 2; a++)
            begin
                ctl = 16'($random(seed));
                ctl[15:6] = a ? {c[3:0], 6'h00} : {4'h0, c[3:0], 2'b00};
                for (int k = 0; k < NUM_SRC; k++)
                begin
                    rawSrc[k] = rnd();
                    filtSrc[k] = rnd();
                end
                diagIn = ($random(seed) % 2 == 0) ? 16'h0300 : 16'($random(seed));
                v = (c >= 1 && c <= 8) ? (ctl[3] ? filtSrc[c-1] : rawSrc[c-1]) : 16'h0000;
                thr = ($random(seed) % 4 == 0) ? v : rnd();
                if (c >= 1 && c <= 8)
                    hit = ctl[a ? 5 : 4] ? $signed(v) > $signed(thr) : $signed(v) < $signed(thr);
                else
                    hit = (c == 9) ? |(diagIn & 16'hfcff) : 1'b0;
                i_dam_host_model.wr16(a ? ADDR_THR_TWO : ADDR_THR_ONE, thr);
                i_dam_host_model.wr16(ADDR_CTRL, ctl);
                pulse();
                chkAlarm(ctl, a ? 1'b0 : hit, a ? hit : 1'b0);
            end
        // dynamic: change across the window on z rate, window boundaries 0, 1, 3
        for (int a = 0; a < 2; a++)
            for (int w = 0; w < 4; w++)
            begin
                if (w == 2)
                    continue;
                n = (w < 2) ? 1 : w;
                ctl = {8'($random(seed))};
                ctl[15:6] = a ? 10'b0011000010 : 10'b0000001101;
                ctl[3] = 1'b0;
                thr = 16'($random(seed) % 300);
                i_dam_host_model.wr8(a ? ADDR_WIN_TWO : ADDR_WIN_ONE, 8'(w));
                i_dam_host_model.wr16(a ? ADDR_THR_TWO : ADDR_THR_ONE, thr);
                i_dam_host_model.wr16(ADDR_CTRL, ctl);
                hist.delete();
                for (int s = 0; s < n + 6; s++)
                begin
                    rawSrc[2] = rnd();
                    hist.push_back(rawSrc[2]);
                    pulse();
                    if (hist.size() > n)
                    begin
                        d = hist[$] - hist[$-n];
                        hit = ctl[a ? 5 : 4] ? $signed(d) > $signed(thr)
                                             : $signed(d) < $signed(thr);
                        chkAlarm(ctl, a ? 1'b0 : hit, a ? hit : 1'b0);
                    end
                end
            end
        repeat (4) @(posedge ref_clk);
        if (expQ.size() != 0)
            check("reads pending", 16'h0000, 16'(expQ.size()));
        test_done();
    end
endmodule : dam_monitor_tb_top
